// file: design/master_pic_map.vh
/*
 * Constants for the master interrupt controller command/status port:
 * port addresses, command word field positions, select codes, reset values.
 * Assumes it is included by bare name from design files.
 */
`ifndef MASTER_PIC_MAP_VH
`define MASTER_PIC_MAP_VH

// ==========================================================================
// port addresses
`define CMD_PORT_ADDR      16'h0020
`define DATA_PORT_ADDR     16'h0021

// ==========================================================================
// command port write decode
`define INIT_SEL_BIT       4
`define OP3_SEL_BIT        3
`define TRIG_MODE_BIT      3
`define VEC_INTERVAL_BIT   2
`define SINGLE_BIT         1
`define WORD4_NEEDED_BIT   0
`define READ_SEL_HI        1
`define READ_SEL_LO        0

// ==========================================================================
// read select codes and fixed values
`define SEL_REQUEST        2'h2
`define SEL_IN_SERVICE     2'h3
`define VEC_INTERVAL_FIXED 1'h1
`define WORD4_DEFAULT      8'h01

// ==========================================================================
// initialization sequence pointer codes
`define SEQ_IDLE           2'h0
`define SEQ_WORD2          2'h1
`define SEQ_WORD3          2'h2
`define SEQ_WORD4          2'h3

`endif

// file: design/source_combiner.v
/*
 * Combines mapped interrupt sources onto the eight master request lines
 * and the single non-maskable line.
 * Assumes each source carries a 5-bit channel code from an outside mapping
 * register; codes 1,2,3,11,12,13,21,22 reach master inputs 0..7, 31 is NMI.
 */
`timescale 1ns/1ps

module source_combiner #(
    parameter NUM_SRC = 8
) (
    // sources and their mapping codes
    input  wire [NUM_SRC-1:0]   srcLevel,
    input  wire [NUM_SRC*5-1:0] srcMap,
    // combined lines
    output reg  [7:0]           chanReq,
    output reg                  nmiReq
);

    // ======================================================================
    // code of master channel n
    function [4:0] chanCode;
        input [2:0] n;
        begin
            case (n)
                3'h0:    chanCode = 5'h01;
                3'h1:    chanCode = 5'h02;
                3'h2:    chanCode = 5'h03;
                3'h3:    chanCode = 5'h0B;
                3'h4:    chanCode = 5'h0C;
                3'h5:    chanCode = 5'h0D;
                3'h6:    chanCode = 5'h15;
                default: chanCode = 5'h16;
            endcase
        end
    endfunction

    integer s;
    integer c;

    // ======================================================================
    // wired-or sharing: any source on a code drives that line
    always @* begin
        chanReq = 8'h00;
        nmiReq  = 1'b0;
        for (s = 0; s < NUM_SRC; s = s + 1) begin
            for (c = 0; c < 8; c = c + 1) begin
                if (srcMap[s*5 +: 5] == chanCode(c[2:0])) begin
                    chanReq[c] = chanReq[c] | srcLevel[s]; // RQ3
                end
            end
            if (srcMap[s*5 +: 5] == 5'h1F) begin
                nmiReq = nmiReq | srcLevel[s]; // RQ4
            end
        end
    end

endmodule

// file: design/master_pic_status.v
/*
 * Master interrupt controller command/status port: status read-back
 * select, first initialization word, initialization word sequencing,
 * cascade folding of the two slave controllers onto channels 2 and 5.
 * Assumes a synchronous host I/O strobe interface on clk; request and
 * slave inputs come from pins and are synchronised here.
 */
// Functional notes
// RQ1 - remap sources only while channel masked
// RQ2 - map NMI sources while NMI enable clear
// RQ3 - sources sharing a channel are or-ed
// RQ4 - NMI sources share one NMI line
// RQ5 - request status shows eight live inputs
// RQ6 - requests latch until acknowledged; in level mode the latch here drops with its input
// RQ7 - select 0Ah then read gives requests
// RQ8 - bit 2 reflects any first-slave request
// RQ9 - bit 5 reflects any second-slave request
// RQ10 - in-service status holds eight levels
// RQ11 - select 0Bh then read gives in-service
// RQ12 - in-service bit 2 from first slave
// RQ13 - in-service bit 5 from second slave
// RQ14 - bit 4 set loads word one, sequence
// RQ15 - bit 4 clear: bit 3 picks op word
// RQ16 - software writes zero to reserved bits
// RQ17 - word-one bit 3 picks edge or level
// RQ18 - trigger bit only under global mode
// RQ19 - vector interval fixed at one
// RQ20 - single skips word three
// RQ21 - single mode bypasses slaves, input 0
// RQ22 - fourth word internal unless requested
// RQ23 - word one resets sequence and state
// RQ24 - software always writes words one, two
// RQ25 - read select 10/11 picks status
// RQ26 - default read returns request status
`timescale 1ns/1ps
`include "master_pic_map.vh"

module master_pic_status #(
    parameter NUM_SRC = 8
) (
    // clock and reset
    input  wire                 clk,
    input  wire                 rst,
    // host I/O port access
    input  wire [15:0]          ioAddr,
    input  wire                 ioWr,
    input  wire                 ioRd,
    input  wire [7:0]           ioWrData,
    output reg  [7:0]           ioRdData_ff,
    output reg                  ioRdValid_ff,
    // mapped interrupt sources
    input  wire [NUM_SRC-1:0]   srcLevel,
    input  wire [NUM_SRC*5-1:0] srcMap,
    // slave controller activity
    input  wire [7:0]           slaveOneReq,
    input  wire [7:0]           slaveTwoReq,
    input  wire [7:0]           slaveOneService,
    input  wire [7:0]           slaveTwoService,
    // acknowledge and end of interrupt per master level
    input  wire [7:0]           levelAck,
    input  wire [7:0]           levelEoi,
    // global control bits
    input  wire                 masterGlobalModeSelect,
    input  wire [7:0]           masterPerChannelMode,
    input  wire                 globalNonmaskableEnable,
    // outputs
    output reg  [7:0]           chanLevelMode_ff,
    output reg                  nmiOut_ff,
    output reg                  singleMode_ff,
    output reg  [7:0]           initWordTwo_ff,
    output reg  [7:0]           initWordThree_ff,
    output reg  [7:0]           initWordFour_ff,
    output reg  [7:0]           opWordTwo_ff,
    output reg                  opWordTwoStb_ff,
    output reg  [6:0]           opWordThree_ff,
    output reg                  opWordThreeStb_ff
);

    // ======================================================================
    // port decode
    // full 16-bit compare: aliases of the two ports are not decoded
    // reads of the data port get no answer from this block
    wire cmdWr  = ioWr && (ioAddr == `CMD_PORT_ADDR);
    wire dataWr = ioWr && (ioAddr == `DATA_PORT_ADDR);
    wire cmdRd  = ioRd && (ioAddr == `CMD_PORT_ADDR);
    wire initSel = ioWrData[`INIT_SEL_BIT];            // word one select

    // ======================================================================
    // pin synchronisers: stage one read only by stage two
    wire [7:0]  combReq;
    wire        combNmi;
    reg  [40:0] syncA_ff;
    reg  [40:0] syncB_ff;
    wire [40:0] rawIn = {combNmi, combReq, slaveOneReq, slaveTwoReq,
                         slaveOneService, slaveTwoService};

    source_combiner #(
        .NUM_SRC (NUM_SRC)
    ) u_comb (
        .srcLevel (srcLevel),
        .srcMap   (srcMap),
        .chanReq  (combReq),
        .nmiReq   (combNmi)
    );

    // two-stage capture of all asynchronous inputs
    // acknowledge and end of interrupt come from logic on clk and skip
    // this path; sources are combined first so one pair of stages serves
    // every source, at the cost of two cycles of latency
    always @(posedge clk) begin
        if (rst) begin
            syncA_ff <= 41'h0;
            syncB_ff <= 41'h0;
        end else begin
            syncA_ff <= rawIn;
            syncB_ff <= syncA_ff;
        end
    end

    // unpacked views of the second stage
    // the top bit carries the combined non-maskable line
    wire       sNmi   = syncB_ff[40];
    wire [7:0] sReq   = syncB_ff[39:32];
    wire [7:0] sS1Req = syncB_ff[31:24];
    wire [7:0] sS2Req = syncB_ff[23:16];
    wire [7:0] sS1Svc = syncB_ff[15:8];
    wire [7:0] sS2Svc = syncB_ff[7:0];

    // ======================================================================
    // configuration state
    // word one fields stay here until the next word one rewrites them
    reg        trigMode_ff;       // level when set
    reg        word4Needed_ff;    // software writes word four
    reg        vecInterval_ff;    // fixed spacing of four
    reg [1:0]  seqPtr_ff;         // initialization word pointer
    reg        readSelIsr_ff;     // status read select
    reg [7:0]  reqLatch_ff;       // latched requests
    reg [7:0]  prevReq_ff;        // for edge detection

    // ======================================================================
    // effective request inputs with cascade folding
    reg [7:0] effReq;
    reg [7:0] effSvc;
    // cascade mode: any request or level of a slave shows on its bit
    // in single mode a detached slave's in-service levels are not shown
    // slaves detached in single mode: their input 0 goes straight through
    always @* begin
        effReq = sReq;
        effSvc = 8'h00;
        if (singleMode_ff) begin
            effReq[2] = sReq[2] | sS1Req[0];                 // RQ21
            effReq[5] = sReq[5] | sS2Req[0];                 // RQ21
        end else begin
            effReq[2] = sReq[2] | (|sS1Req);                 // RQ8
            effReq[5] = sReq[5] | (|sS2Req);                 // RQ9
            effSvc[2] = |sS1Svc;                             // RQ12
            effSvc[5] = |sS2Svc;                             // RQ13
        end
    end

    // per-channel detection mode: global bit only under global mode
    // registered, so a mode change reaches the latch one cycle later
    wire [7:0] nxt_chanLevelMode = masterGlobalModeSelect ?
                                   {8{trigMode_ff}} : masterPerChannelMode; // RQ18

    // ======================================================================
    // request latch: edge or level capture, held until acknowledged
    // edge mode needs a low-to-high step seen against prevReq_ff
    // level mode drops the latch as soon as the input drops
    wire [7:0] reqEvent = (chanLevelMode_ff & effReq) |
                          (~chanLevelMode_ff & effReq & ~prevReq_ff);     // RQ17
    // a new event beats an acknowledge in the same cycle
    wire [7:0] nxt_reqLatch = (reqEvent | (reqLatch_ff & ~levelAck)) &
                              (effReq | ~chanLevelMode_ff);               // RQ6

    // live inputs or held events are visible
    // a latched edge stays visible after its input has gone low
    wire [7:0] reqStatus = effReq | reqLatch_ff;                         // RQ5

    // ======================================================================
    // in-service levels: set on acknowledge, cleared on end of interrupt
    // acknowledge wins over end of interrupt when both land together
    reg [7:0] inService_ff;
    wire [7:0] nxt_inService = (inService_ff & ~levelEoi) | levelAck;
    wire [7:0] svcStatus = inService_ff | effSvc;                        // RQ10

    // ======================================================================
    // command and data port writes
    // word one outranks the op words: bit 4 is tested first
    // op word strobes are one-cycle pulses, dropped every cycle by default
    always @(posedge clk) begin
        if (rst) begin
            trigMode_ff       <= 1'b0;
            singleMode_ff     <= 1'b0;
            word4Needed_ff    <= 1'b0;
            vecInterval_ff    <= `VEC_INTERVAL_FIXED;
            seqPtr_ff         <= `SEQ_IDLE;
            readSelIsr_ff     <= 1'b0;
            initWordTwo_ff    <= 8'h00;
            initWordThree_ff  <= 8'h00;
            initWordFour_ff   <= 8'h00;
            opWordTwo_ff      <= 8'h00;
            opWordTwoStb_ff   <= 1'b0;
            opWordThree_ff    <= 7'h00;
            opWordThreeStb_ff <= 1'b0;
        end else begin
            opWordTwoStb_ff   <= 1'b0;
            opWordThreeStb_ff <= 1'b0;
            if (cmdWr && initSel) begin
                // word one: capture fields, restart sequence
                trigMode_ff    <= ioWrData[`TRIG_MODE_BIT];              // RQ17
                singleMode_ff  <= ioWrData[`SINGLE_BIT];                 // RQ20
                word4Needed_ff <= ioWrData[`WORD4_NEEDED_BIT];
                vecInterval_ff <= `VEC_INTERVAL_FIXED;                   // RQ19
                seqPtr_ff      <= `SEQ_WORD2;                            // RQ23
                readSelIsr_ff  <= 1'b0;                                  // RQ26
                // word four is filled in only when software will not write it
                if (!ioWrData[`WORD4_NEEDED_BIT]) begin
                    initWordFour_ff <= `WORD4_DEFAULT;                   // RQ22
                end
            end else if (cmdWr) begin
                // bit 3 picks which operation word
                if (ioWrData[`OP3_SEL_BIT]) begin
                    opWordThree_ff    <= ioWrData[6:0];                  // RQ15
                    opWordThreeStb_ff <= 1'b1;
                    // select codes 00 and 01 leave the status choice alone
                    if (ioWrData[`READ_SEL_HI]) begin
                        readSelIsr_ff <= ioWrData[`READ_SEL_LO];         // RQ25
                    end
                end else begin
                    opWordTwo_ff    <= ioWrData;                         // RQ15
                    opWordTwoStb_ff <= 1'b1;
                end
            end else if (dataWr) begin
                // data port walks the initialization words
                case (seqPtr_ff)
                    `SEQ_WORD2: begin
                        // word two always comes; the rest follows word one
                        initWordTwo_ff <= ioWrData;                      // RQ14
                        if (!singleMode_ff) begin
                            seqPtr_ff <= `SEQ_WORD3;                     // RQ20
                        end else if (word4Needed_ff) begin
                            seqPtr_ff <= `SEQ_WORD4;                     // RQ20
                        end else begin
                            seqPtr_ff <= `SEQ_IDLE;                      // RQ22
                        end
                    end
                    `SEQ_WORD3: begin
                        // only reached in cascade mode
                        initWordThree_ff <= ioWrData;                    // RQ14
                        seqPtr_ff <= word4Needed_ff ? `SEQ_WORD4 : `SEQ_IDLE; // RQ22
                    end
                    `SEQ_WORD4: begin
                        // an explicit fourth word overrides the default
                        initWordFour_ff <= ioWrData;                     // RQ22
                        seqPtr_ff       <= `SEQ_IDLE;
                    end
                    default: begin
                        // outside a sequence the data port is not ours
                        seqPtr_ff <= `SEQ_IDLE;
                    end
                endcase
            end
        end
    end

    // ======================================================================
    // status latches and outputs
    // prevReq_ff follows the folded inputs so a cascade edge is caught too
    always @(posedge clk) begin
        if (rst) begin
            reqLatch_ff      <= 8'h00;
            prevReq_ff       <= 8'h00;
            inService_ff     <= 8'h00;
            chanLevelMode_ff <= 8'h00;
            nmiOut_ff        <= 1'b0;
        end else begin
            reqLatch_ff      <= nxt_reqLatch;
            prevReq_ff       <= effReq;
            inService_ff     <= nxt_inService;
            chanLevelMode_ff <= nxt_chanLevelMode;
            // the gate sits after the synchroniser, so enabling acts at the next clock edge
            // NMI passes only while the global enable is set
            nmiOut_ff        <= sNmi & globalNonmaskableEnable;          // RQ4
        end
    end

    // ======================================================================
    // command port read: one-cycle answer after the strobe
    // the valid pulse stands one cycle; the data stays until the next read
    // a read of any other address leaves the data untouched and the valid low
    // the select is read as it stood before the read edge
    always @(posedge clk) begin
        if (rst) begin
            ioRdData_ff  <= 8'h00;
            ioRdValid_ff <= 1'b0;
        end else begin
            ioRdValid_ff <= cmdRd;
            if (cmdRd) begin
                ioRdData_ff <= readSelIsr_ff ? svcStatus : reqStatus;    // RQ7 RQ11
            end
        end
    end

endmodule

// file: sim/master_pic_status_properties.sv
/* checker for the master controller command port: strobes, read answer,
   init word loading. assumes a bind onto master_pic_status. */
`timescale 1ns/1ps
module master_pic_status_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // host access
    input wire logic [15:0] ioAddr,
    input wire logic        ioWr,
    input wire logic        ioRd,
    input wire logic [7:0]  ioWrData,
    input wire logic        ioRdValid_ff,
    // controls and results
    input wire logic        masterGlobalModeSelect,
    input wire logic [7:0]  masterPerChannelMode,
    input wire logic        globalNonmaskableEnable,
    input wire logic [7:0]  chanLevelMode_ff,
    input wire logic        nmiOut_ff,
    input wire logic        singleMode_ff,
    input wire logic [7:0]  initWordTwo_ff,
    input wire logic [7:0]  initWordFour_ff,
    input wire logic [7:0]  opWordTwo_ff,
    input wire logic        opWordTwoStb_ff,
    input wire logic [6:0]  opWordThree_ff,
    input wire logic        opWordThreeStb_ff
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// ==========================================
// command and data port decode steps
sequence s_cmd_wr; ioWr && ioAddr == 16'h0020; endsequence
sequence s_word_one; s_cmd_wr ##0 ioWrData[4]; endsequence
sequence s_data_wr; ioWr && ioAddr == 16'h0021; endsequence
// ==========================================
// properties
a_read_answer: assert property (ioRd && ioAddr == 16'h0020 |=> ioRdValid_ff)
    else $error("command port read got no answer");
a_no_stray: assert property (!(ioRd && ioAddr == 16'h0020) |=> !ioRdValid_ff)
    else $error("read answer without a command port read");
a_word_quiet: assert property (s_word_one |=> !opWordTwoStb_ff && !opWordThreeStb_ff)
    else $error("init word taken as an op word");
a_op_two: assert property (s_cmd_wr ##0 ioWrData[4:3] == 2'h0
    |=> opWordTwoStb_ff && opWordTwo_ff == $past(ioWrData)) else $error("op word two lost");
a_op_three: assert property (s_cmd_wr ##0 ioWrData[4:3] == 2'h1
    |=> opWordThreeStb_ff && opWordThree_ff == $past(ioWrData[6:0]))
    else $error("op word three lost");
a_single_load: assert property (s_word_one |=> singleMode_ff == $past(ioWrData[1]))
    else $error("single bit not loaded");
a_word4_default: assert property (s_word_one ##0 !ioWrData[0] |=> initWordFour_ff == 8'h01)
    else $error("fourth word not set internally");
a_word_two: assert property (s_word_one ##2 s_data_wr |=> initWordTwo_ff == $past(ioWrData))
    else $error("second word not loaded after first");
a_chan_mode: assert property ((!masterGlobalModeSelect && $stable(masterPerChannelMode))[*3]
    |-> chanLevelMode_ff == masterPerChannelMode) else $error("per-channel mode ignored");
a_nmi_gate: assert property (!globalNonmaskableEnable [*2] |-> !nmiOut_ff)
    else $error("nmi passed while disabled");
endmodule

// file: sim/pic_host_model.sv
/* host processor model: I/O port writes and reads, one strobe a cycle.
   assumes the design answers a read one cycle after the strobe edge. */
`timescale 1ns/1ps
module pic_host_model (
    // clock
    input  wire logic        clk,
    // host access
    output logic      [15:0] ioAddr,
    output logic             ioWr,
    output logic             ioRd,
    output logic      [7:0]  ioWrData,
    input  wire logic [7:0]  ioRdData_ff,
    input  wire logic        ioRdValid_ff
);
// idle bus at time zero
initial begin
    ioAddr = 16'hFFFF;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
end
// one write; released lines show inverted values so stale data never matches
task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    ioAddr <= a;
    ioWrData <= d;
    ioWr <= 1'b1;
    @(posedge clk);
    ioWr <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~d;
endtask
// one read; answer taken at the edge after the one that registers it
task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    ioAddr <= a;
    ioRd <= 1'b1;
    @(posedge clk);
    ioRd <= 1'b0;
    ioAddr <= ~a;
    @(posedge clk);
    v = ioRdValid_ff;
    d = ioRdData_ff;
endtask
endmodule

// file: sim/master_pic_status_tb.sv
/* self-checking bench for master_pic_status: init sequences, status reads,
   cascade folding, modes, nmi. assumes the host model drives the port. */
`timescale 1ns/1ps
module master_pic_status_tb;
logic clk = 1'b0, rst = 1'b1, masterGlobalModeSelect = 1'b1, globalNonmaskableEnable = 1'b0;
logic [7:0] srcLevel = 8'h00, slaveOneReq = 8'h00, slaveTwoReq = 8'h00, rdData;
logic [7:0] slaveOneService = 8'h00, slaveTwoService = 8'h00, levelAck = 8'h00;
logic [7:0] levelEoi = 8'h00, masterPerChannelMode = 8'h00, chanLevelMode_ff;
logic [7:0] initWordTwo_ff, initWordThree_ff, initWordFour_ff, ioWrData, ioRdData_ff;
logic [39:0] srcMap = {5'h1F, 5'h1F, 15'h0000, 5'h0B, 5'h0B, 5'h01};
logic [15:0] ioAddr;
logic ioWr, ioRd, ioRdValid_ff, nmiOut_ff, singleMode_ff, rdOk;
int err_total = 0, n_checks = 0, cycles = 0;
always #12.5 clk = ~clk;
// ==========================================
// design, host, checker
master_pic_status #(.NUM_SRC(8)) DUT (.clk(clk), .rst(rst), .ioAddr(ioAddr),
    .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData_ff(ioRdData_ff),
    .ioRdValid_ff(ioRdValid_ff), .srcLevel(srcLevel), .srcMap(srcMap),
    .slaveOneReq(slaveOneReq), .slaveTwoReq(slaveTwoReq), .slaveOneService(slaveOneService),
    .slaveTwoService(slaveTwoService), .levelAck(levelAck), .levelEoi(levelEoi),
    .masterGlobalModeSelect(masterGlobalModeSelect), .masterPerChannelMode(masterPerChannelMode),
    .globalNonmaskableEnable(globalNonmaskableEnable), .chanLevelMode_ff(chanLevelMode_ff),
    .nmiOut_ff(nmiOut_ff), .singleMode_ff(singleMode_ff), .initWordTwo_ff(initWordTwo_ff),
    .initWordThree_ff(initWordThree_ff), .initWordFour_ff(initWordFour_ff), .opWordTwo_ff(),
    .opWordTwoStb_ff(), .opWordThree_ff(), .opWordThreeStb_ff());
pic_host_model H (.clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWrData(ioWrData), .ioRdData_ff(ioRdData_ff), .ioRdValid_ff(ioRdValid_ff));
// ==========================================
// compare, read and closing tasks
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic rdchk(input logic [7:0] exp);
    H.rd(16'h0020, rdData, rdOk);
    chk({7'h00, rdOk}, 8'h01);
    chk(rdData, exp);
endtask
// inputs cross two sync flops plus a latch, so six edges is ample
task automatic settle;
    repeat (6) @(posedge clk);
endtask
task automatic done(input string name);
    $display("test %s finished", name);
endtask
task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
// hang guard: the sequence needs well under a thousand cycles
always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
        err_total++;
        $display("CHECK FAILED t=%0t run did not finish", $time);
        results;
    end
end
// ==========================================
// main sequence
initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    H.wr(16'h0020, 8'h19);
    H.wr(16'h0021, 8'h20);
    H.wr(16'h0021, 8'h24);
    H.wr(16'h0021, 8'h03);
    @(posedge clk);
    chk(initWordTwo_ff, 8'h20);
    chk(initWordThree_ff, 8'h24);
    chk(initWordFour_ff, 8'h03);
    chk({7'h00, singleMode_ff}, 8'h00);
    chk(chanLevelMode_ff, 8'hFF);
    done("init");
    srcLevel <= 8'h03;
    settle;
    rdchk(8'h09);
    @(posedge clk);
    srcLevel <= 8'h04;
    settle;
    rdchk(8'h08);
    done("mapping");
    H.wr(16'h0020, 8'h0A);
    @(posedge clk);
    srcLevel <= 8'h00;
    slaveOneReq <= 8'h80;
    slaveTwoReq <= 8'h10;
    settle;
    rdchk(8'h24);
    H.wr(16'h0030, 8'hFF);
    H.rd(16'h0021, rdData, rdOk);
    chk({7'h00, rdOk}, 8'h00);
    done("cascade request");
    slaveOneService <= 8'h40;
    slaveTwoService <= 8'h01;
    levelAck <= 8'h01;
    @(posedge clk);
    levelAck <= 8'h00;
    H.wr(16'h0020, 8'h0B);
    settle;
    rdchk(8'h25);
    H.wr(16'h0020, 8'h08);
    rdchk(8'h25);
    @(posedge clk);
    levelEoi <= 8'h01;
    @(posedge clk);
    levelEoi <= 8'h00;
    settle;
    rdchk(8'h24);
    done("in service");
    H.wr(16'h0020, 8'h1A);
    settle;
    rdchk(8'h00);
    @(posedge clk);
    slaveOneReq <= 8'h01;
    slaveTwoReq <= 8'h01;
    settle;
    rdchk(8'h24);
    H.wr(16'h0021, 8'h30);
    H.wr(16'h0021, 8'h55);
    chk(initWordTwo_ff, 8'h30);
    chk(initWordThree_ff, 8'h24);
    chk(initWordFour_ff, 8'h01);
    H.wr(16'h0020, 8'h0B);
    rdchk(8'h00);
    done("single");
    slaveOneReq <= 8'h00;
    slaveTwoReq <= 8'h00;
    H.wr(16'h0020, 8'h13);
    H.wr(16'h0021, 8'h40);
    H.wr(16'h0021, 8'h0F);
    @(posedge clk);
    chk(initWordFour_ff, 8'h0F);
    chk(chanLevelMode_ff, 8'h00);
    srcLevel <= 8'h01;
    repeat (4) @(posedge clk);
    srcLevel <= 8'h00;
    settle;
    rdchk(8'h01);
    @(posedge clk);
    levelAck <= 8'h01;
    @(posedge clk);
    levelAck <= 8'h00;
    settle;
    rdchk(8'h00);
    masterGlobalModeSelect <= 1'b0;
    masterPerChannelMode <= 8'hA5;
    settle;
    chk(chanLevelMode_ff, 8'hA5);
    done("edge latch");
    srcLevel <= 8'h80;
    settle;
    chk({7'h00, nmiOut_ff}, 8'h00);
    globalNonmaskableEnable <= 1'b1;
    settle;
    chk({7'h00, nmiOut_ff}, 8'h01);
    srcLevel <= 8'h40;
    settle;
    chk({7'h00, nmiOut_ff}, 8'h01);
    srcLevel <= 8'h00;
    settle;
    chk({7'h00, nmiOut_ff}, 8'h00);
    H.wr(16'h0020, 8'h40);
    done("nmi");
    results;
end
endmodule
bind master_pic_status master_pic_status_properties CHK (.clk(clk), .rst(rst),
    .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
    .ioRdValid_ff(ioRdValid_ff), .masterGlobalModeSelect(masterGlobalModeSelect),
    .masterPerChannelMode(masterPerChannelMode),
    .globalNonmaskableEnable(globalNonmaskableEnable), .chanLevelMode_ff(chanLevelMode_ff),
    .nmiOut_ff(nmiOut_ff), .singleMode_ff(singleMode_ff), .initWordTwo_ff(initWordTwo_ff),
    .initWordFour_ff(initWordFour_ff), .opWordTwo_ff(opWordTwo_ff),
    .opWordTwoStb_ff(opWordTwoStb_ff), .opWordThree_ff(opWordThree_ff),
    .opWordThreeStb_ff(opWordThreeStb_ff));
